// ==== src/cpurb_pkg.sv ====
package cpurb_pkg;

	// ==========================================
	// Bus register byte offsets
	localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h00;
	localparam logic [7:0] OFS_ACCUMULATOR = 8'h04;
	localparam logic [7:0] OFS_TEMPORARY_ACCUMULATOR = 8'h08;
	localparam logic [7:0] OFS_INDEX_REGISTER = 8'h0c;
	localparam logic [7:0] OFS_EXTRA_POINTER = 8'h10;
	localparam logic [7:0] OFS_STACK_POINTER = 8'h14;
	localparam logic [7:0] OFS_STATUS_WORD = 8'h18;
	localparam logic [7:0] OFS_MAP_STATUS = 8'h1c;

	// ==========================================
	// Status word field positions
	localparam int BANK_SELECT_LSB = 11;
	localparam int BANK_SELECT_W = 5;
	localparam int DIRECT_WINDOW_LSB = 8;
	localparam int DIRECT_WINDOW_W = 3;
	localparam int FLAG_H = 7;
	localparam int FLAG_I = 6;
	localparam int FLAG_IL_LSB = 4;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;

	// ==========================================
	// Reset values and address constants
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] RESET_STATUS_WORD = 16'h0030;
	localparam logic [7:0] GEN_AREA_BASE = 8'h01;
	localparam logic [15:0] DIRECT_WINDOW_LOW = 16'h0080;
	localparam logic [15:0] DIRECT_WINDOW_STEP = 16'h0080;

	// ==========================================
	// Types
	typedef enum logic [2:0] {
		SEL_PC, SEL_ACC, SEL_TMP, SEL_IDX, SEL_EP, SEL_SP, SEL_PS
	} cpurb_sel_e;

	typedef enum logic [1:0] {
		OP_ADD, OP_SUB, OP_SHL, OP_SHR
	} cpurb_op_e;

	typedef struct packed {
		logic en;
		cpurb_sel_e sel;
		logic byte_only;
		logic [15:0] data;
	} cpurb_wr_s;

	typedef struct packed {
		logic go;
		cpurb_op_e op;
		logic wide;
		logic [4:0] affect;
	} cpurb_alu_s;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [15:0] idx;
		logic [15:0] ep;
		logic [15:0] sp;
		logic [15:0] ps;
	} cpurb_file_s;

endpackage

// ==== src/cpurb_regs.sv ====
// Operation
// [RULE_01] Program counter is a 16-bit register addressing the next fetch.
// [RULE_02] Accumulator is 16 bits; byte operations use only its low byte.
// [RULE_03] Temporary accumulator is the second 16-bit operand; byte ops use low byte.
// [RULE_04] Index register is 16 bits, used to modify indexed addresses.
// [RULE_05] Extra pointer is 16 bits holding a memory address for pointer accesses.
// [RULE_06] Stack pointer is 16 bits, marking the current stack location.
// [RULE_07] Status word: bank and window selectors high byte, flags low byte.
// [RULE_08] General address: zeros, one at bit 8, bank bits, low opcode bits.
// [RULE_09] Direct 0x00-0x7F unmapped; 0x80-0xFF moved up 0x80 per window step.
// [RULE_10] Half-carry flag follows carry or borrow between bits 3 and 4.
// [RULE_11] Interrupt enable flag allows interrupts when one; reset clears it.
// [RULE_12] Level mask 0..3; a request needs higher priority than the mask.
// [RULE_13] Negative flag copies the result's most significant bit.
// [RULE_14] Zero flag set for zero result, cleared otherwise.
// [RULE_15] Overflow flag follows two's complement overflow of the result.
// [RULE_16] Carry flag from bit 7 carry or borrow; shifts load shifted-out bit.
// [RULE_17] General registers: eight 8-bit slots per bank, up to 32 banks.
// [RULE_18] Only flags an instruction affects change; all others keep value.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
module cpurb_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core register write port
	input wire cpurb_pkg::cpurb_wr_s core_wr,
	// Arithmetic request on accumulator and temporary
	input wire cpurb_pkg::cpurb_alu_s alu_req,
	// Address generation requests
	input wire logic [2:0] opcode_low,
	input wire logic [15:0] direct_addr,
	// Interrupt request
	input wire logic irq_pending,
	input wire logic [1:0] irq_level,
	// Register file view
	output cpurb_pkg::cpurb_file_s file_out,
	// Generated addresses and interrupt decision
	output logic [15:0] general_addr,
	output logic [15:0] mapped_addr,
	output logic irq_accept
);
	import cpurb_pkg::*;

	// ==========================================
	// Reset synchroniser
	logic rst_meta_q;
	logic rst_sync_n_q;

	// Two flops release reset cleanly
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// ==========================================
	// State
	typedef struct packed {
		cpurb_file_s f;
		logic [31:0] rdata;
		logic ack;
		logic [15:0] gen_addr;
		logic [15:0] map_addr;
		logic irq_ok;
	} cpurb_state_s;

	cpurb_state_s s_q;
	cpurb_state_s s_d;

	// ==========================================
	// Functions

	// Merge bus write data into a 16-bit register by byte lanes
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Core write: a byte write keeps the upper byte
	function automatic logic [15:0] core_merge(input logic [15:0] old,
			input cpurb_wr_s w);
		logic [15:0] r;
		r = w.byte_only ? {old[15:8], w.data[7:0]} : w.data;
		return r;
	endfunction

	// Direct address remap through the window selector
	function automatic logic [15:0] window_map(input logic [15:0] a,
			input logic [2:0] sel);
		logic [15:0] r;
		r = a;
		if (a[15:7] == 9'h001) begin
			r = a + 16'(sel) * DIRECT_WINDOW_STEP;
		end
		return r;
	endfunction

	// ==========================================
	// Arithmetic and flags
	logic [15:0] op_a;
	logic [15:0] op_b;
	logic [16:0] sum;
	logic [15:0] res;
	logic msb_a;
	logic msb_b;
	logic msb_r;
	logic carry;
	logic half;
	logic ovf;
	logic [7:0] new_flags;

	// Operands; byte mode uses only the low bytes
	always_comb begin
		op_a = alu_req.wide ? s_q.f.acc : {8'h00, s_q.f.acc[7:0]};
		op_b = alu_req.wide ? s_q.f.tmp : {8'h00, s_q.f.tmp[7:0]};
		sum = 17'h00000;
		res = 16'h0000;
		carry = 1'b0;
		case (alu_req.op)
			// [RULE_03] second operand
			OP_ADD: begin
				sum = {1'b0, op_a} + {1'b0, op_b};
				res = sum[15:0];
				carry = alu_req.wide ? sum[16] : sum[8];
			end
			OP_SUB: begin
				sum = {1'b0, op_a} - {1'b0, op_b};
				res = sum[15:0];
				carry = alu_req.wide ? sum[16] : sum[8];
			end
			// [RULE_16] shifted-out bit
			OP_SHL: begin
				res = {op_a[14:0], 1'b0};
				carry = alu_req.wide ? op_a[15] : op_a[7];
			end
			OP_SHR: begin
				res = {1'b0, op_a[15:1]};
				if (!alu_req.wide) begin
					res[7] = 1'b0;
				end
				carry = op_a[0];
			end
			default: begin
				res = op_a;
			end
		endcase
		if (!alu_req.wide) begin
			res[15:8] = 8'h00;
		end
		msb_a = alu_req.wide ? op_a[15] : op_a[7];
		msb_b = alu_req.wide ? op_b[15] : op_b[7];
		msb_r = alu_req.wide ? res[15] : res[7];
		// [RULE_10] bit 3 to 4 carry
		half = op_a[4] ^ op_b[4] ^ res[4];
		// [RULE_15] two's complement overflow
		case (alu_req.op)
			OP_ADD: ovf = (msb_a == msb_b) && (msb_r != msb_a);
			OP_SUB: ovf = (msb_a != msb_b) && (msb_r != msb_a);
			default: ovf = 1'b0;
		endcase
		// [RULE_18] unaffected flags hold
		new_flags = s_q.f.ps[7:0];
		if (alu_req.affect[4]) begin
			new_flags[FLAG_H] = half;
		end
		// [RULE_13] negative copies msb
		if (alu_req.affect[3]) begin
			new_flags[FLAG_N] = msb_r;
		end
		// [RULE_14] zero result
		if (alu_req.affect[2]) begin
			new_flags[FLAG_Z] = alu_req.wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
		end
		if (alu_req.affect[1]) begin
			new_flags[FLAG_V] = ovf;
		end
		// [RULE_16] carry out of bit 7, or bit 15 in wide mode
		if (alu_req.affect[0]) begin
			new_flags[FLAG_C] = carry;
		end
	end

	// ==========================================
	// Next state
	logic bus_req;
	logic bus_wr;
	logic [2:0] win_sel;
	logic [4:0] bank_sel;
	logic [1:0] il_mask;

	always_comb begin
		s_d = s_q;
		bus_req = (avs_read || avs_write) && !s_q.ack;
		bus_wr = avs_write && !s_q.ack;
		win_sel = s_q.f.ps[DIRECT_WINDOW_LSB +: DIRECT_WINDOW_W];
		bank_sel = s_q.f.ps[BANK_SELECT_LSB +: BANK_SELECT_W];
		il_mask = s_q.f.ps[FLAG_IL_LSB +: 2];

		// Core writes
		if (core_wr.en) begin
			case (core_wr.sel)
				// [RULE_01] program counter
				SEL_PC: s_d.f.pc = core_merge(s_q.f.pc, core_wr);
				// [RULE_02] accumulator, byte keeps upper
				SEL_ACC: s_d.f.acc = core_merge(s_q.f.acc, core_wr);
				SEL_TMP: s_d.f.tmp = core_merge(s_q.f.tmp, core_wr);
				// [RULE_04] index register
				SEL_IDX: s_d.f.idx = core_merge(s_q.f.idx, core_wr);
				// [RULE_05] extra pointer
				SEL_EP: s_d.f.ep = core_merge(s_q.f.ep, core_wr);
				// [RULE_06] stack pointer
				SEL_SP: s_d.f.sp = core_merge(s_q.f.sp, core_wr);
				// [RULE_07] selectors and flags
				SEL_PS: s_d.f.ps = core_merge(s_q.f.ps, core_wr);
				default: s_d.f = s_q.f;
			endcase
		end

		// Arithmetic result into accumulator; byte ops keep upper byte
		if (alu_req.go) begin
			// [RULE_02] low byte only
			s_d.f.acc = alu_req.wide ? res : {s_q.f.acc[15:8], res[7:0]};
			s_d.f.ps[7:0] = new_flags;
		end

		// Bus writes win over core on the same register
		if (bus_wr) begin
			case (avs_address)
				OFS_PROGRAM_COUNTER: s_d.f.pc = lane_merge(s_q.f.pc, avs_writedata, avs_byteenable);
				OFS_ACCUMULATOR: s_d.f.acc = lane_merge(s_q.f.acc, avs_writedata, avs_byteenable);
				OFS_TEMPORARY_ACCUMULATOR: s_d.f.tmp = lane_merge(s_q.f.tmp, avs_writedata,
					avs_byteenable);
				OFS_INDEX_REGISTER: s_d.f.idx = lane_merge(s_q.f.idx, avs_writedata, avs_byteenable);
				OFS_EXTRA_POINTER: s_d.f.ep = lane_merge(s_q.f.ep, avs_writedata, avs_byteenable);
				OFS_STACK_POINTER: s_d.f.sp = lane_merge(s_q.f.sp, avs_writedata, avs_byteenable);
				OFS_STATUS_WORD: s_d.f.ps = lane_merge(s_q.f.ps, avs_writedata, avs_byteenable);
				default: s_d.f = s_d.f;
			endcase
		end

		// Read data captured with the acknowledge
		s_d.rdata = 32'h00000000;
		if (bus_req && avs_read) begin
			case (avs_address)
				OFS_PROGRAM_COUNTER: s_d.rdata = {16'h0000, s_q.f.pc};
				OFS_ACCUMULATOR: s_d.rdata = {16'h0000, s_q.f.acc};
				OFS_TEMPORARY_ACCUMULATOR: s_d.rdata = {16'h0000, s_q.f.tmp};
				OFS_INDEX_REGISTER: s_d.rdata = {16'h0000, s_q.f.idx};
				OFS_EXTRA_POINTER: s_d.rdata = {16'h0000, s_q.f.ep};
				OFS_STACK_POINTER: s_d.rdata = {16'h0000, s_q.f.sp};
				OFS_STATUS_WORD: s_d.rdata = {16'h0000, s_q.f.ps};
				OFS_MAP_STATUS: s_d.rdata = {s_q.map_addr, s_q.gen_addr};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		s_d.ack = bus_req;

		// [RULE_08] general register address
		// [RULE_17] bank of eight byte slots
		s_d.gen_addr = {GEN_AREA_BASE, bank_sel, opcode_low};
		// [RULE_09] direct window remap
		s_d.map_addr = window_map(direct_addr, win_sel);
		// [RULE_11] enable flag gates requests
		// [RULE_12] level must beat the mask
		s_d.irq_ok = irq_pending && s_q.f.ps[FLAG_I] && (irq_level < il_mask);
	end

	// ==========================================
	// State register
	always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			s_q.f.pc <= RESET_WORD;
			s_q.f.acc <= RESET_WORD;
			s_q.f.tmp <= RESET_WORD;
			s_q.f.idx <= RESET_WORD;
			s_q.f.ep <= RESET_WORD;
			s_q.f.sp <= RESET_WORD;
			// [RULE_11] reset clears enable
			s_q.f.ps <= RESET_STATUS_WORD;
			s_q.rdata <= 32'h00000000;
			s_q.ack <= 1'b0;
			s_q.gen_addr <= RESET_WORD;
			s_q.map_addr <= RESET_WORD;
			s_q.irq_ok <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs straight from flops
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = !s_q.ack; // Low for exactly the acknowledge cycle
	assign file_out = s_q.f;
	assign general_addr = s_q.gen_addr;
	assign mapped_addr = s_q.map_addr;
	assign irq_accept = s_q.irq_ok;

endmodule

// ==== tb/cpurb_dec_model.sv ====
module cpurb_dec_model (
	// Clock
	input wire logic core_clk,
	// Decoder requests
	output cpurb_pkg::cpurb_wr_s core_wr,
	output cpurb_pkg::cpurb_alu_s alu_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import cpurb_pkg::*;
	initial begin
		core_wr = '0;
		alu_req = '0;
	end
	// One-cycle arithmetic pulse
	task automatic alu(input cpurb_op_e op, input logic w, input logic [4:0] af);
		alu_req <= '{1'b1, op, w, af};
		@(posedge core_clk);
		alu_req <= '0;
	endtask
	// One-cycle register write pulse
	task automatic wr(input cpurb_sel_e s, input logic b, input logic [15:0] d);
		core_wr <= '{1'b1, s, b, d};
		@(posedge core_clk);
		core_wr <= '0;
	endtask
endmodule

// ==== tb/cpurb_regs_properties.sv ====
module cpurb_regs_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus handshake
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Core side
	input wire cpurb_pkg::cpurb_wr_s core_wr,
	input wire cpurb_pkg::cpurb_alu_s alu_req,
	input wire logic [2:0] opcode_low,
	input wire logic [15:0] direct_addr,
	input wire logic irq_pending,
	input wire logic [1:0] irq_level,
	input wire cpurb_pkg::cpurb_file_s file_out,
	input wire logic [15:0] general_addr,
	input wire logic [15:0] mapped_addr,
	input wire logic irq_accept
);
	timeunit 1ns;
	timeprecision 1ps;
	import cpurb_pkg::*;
	logic [1:0] warm_q;
	logic quiet, want;
	// Skip the internal two-flop release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			warm_q <= 2'h0;
		else if (warm_q != 2'h3)
			warm_q <= warm_q + 2'h1;
	end
	// No bus or core write competing
	assign quiet = !(avs_write && avs_waitrequest) && !core_wr.en;
	assign want = irq_pending && file_out.ps[FLAG_I] && irq_level < file_out.ps[5:4];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n || warm_q != 2'h3);
	property p_gen;
		general_addr == {8'h01, $past(file_out.ps[15:11]), $past(opcode_low)};
	endproperty
	a_gen: assert property (p_gen) else $error("general address wrong");
	property p_map;
		mapped_addr == ($past(direct_addr[15:7]) == 9'h001 ?
			$past(direct_addr) + {$past(file_out.ps[10:8]), 7'h00} : $past(direct_addr));
	endproperty
	a_map: assert property (p_map) else $error("mapped address wrong");
	property p_irq;
		irq_accept == $past(want);
	endproperty
	a_irq: assert property (p_irq) else $error("irq accept wrong");
	property p_keep;
		alu_req.go && alu_req.affect == 5'h00 && quiet |=> $stable(file_out.ps);
	endproperty
	a_keep: assert property (p_keep) else $error("status changed");
	property p_add;
		alu_req.go && alu_req.wide && alu_req.op == OP_ADD && quiet
			|=> file_out.acc == $past(file_out.acc) + $past(file_out.tmp);
	endproperty
	a_add: assert property (p_add) else $error("wide sum wrong");
	property p_zero;
		alu_req.go && alu_req.wide && alu_req.affect[2] && quiet
			|=> file_out.ps[FLAG_Z] == (file_out.acc == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_neg;
		alu_req.go && alu_req.wide && alu_req.affect[3] && quiet
			|=> file_out.ps[FLAG_N] == file_out.acc[15];
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	property p_byte;
		alu_req.go && !alu_req.wide && quiet |=> $stable(file_out.acc[15:8]);
	endproperty
	a_byte: assert property (p_byte) else $error("upper byte changed");
endmodule
bind cpurb_regs cpurb_regs_checker cpurb_regs_checker_inst (.*);

// ==== tb/test_cpurb_regs.sv ====
module test_cpurb_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import cpurb_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic irq_pending = 1'b0, avs_waitrequest, irq_accept;
	logic [1:0] irq_level = 2'h0;
	logic [2:0] opcode_low = 3'h0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [15:0] direct_addr = 16'h0000, general_addr, mapped_addr, rd, rd_hi;
	logic [3:0] avs_byteenable = 4'h3;
	cpurb_wr_s core_wr;
	cpurb_alu_s alu_req;
	cpurb_file_s file_out;
	int num_errors = 0;
	int n_checks = 0;
	always #4 core_clk = ~core_clk;
	cpurb_regs cpurb_regs_inst (.core_clk(core_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .core_wr(core_wr), .alu_req(alu_req),
		.opcode_low(opcode_low), .direct_addr(direct_addr), .irq_pending(irq_pending),
		.irq_level(irq_level), .file_out(file_out), .general_addr(general_addr),
		.mapped_addr(mapped_addr), .irq_accept(irq_accept));
	cpurb_dec_model cpurb_dec_model_inst (.core_clk(core_clk), .core_wr(core_wr),
		.alu_req(alu_req));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask
	// Avalon-MM transfer, held until waitrequest is low
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		int i = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge core_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			end_sim();
		end
		rd = avs_readdata[15:0];
		rd_hi = avs_readdata[31:16];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 8'(i * 4), 16'h0000);
			chk("reset value", i == 6 ? 16'h0030 : 16'h0000, rd);
			chk("upper half", 16'h0000, rd_hi);
		end
		$display("reset test done");
	endtask
	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 8'(i * 4), 16'hc3a0 ^ 16'(i * 16'h1111));
			bus(1'b0, 8'(i * 4), 16'h0000);
			chk("register", 16'hc3a0 ^ 16'(i * 16'h1111), rd);
		end
		bus(1'b1, 8'h20, 16'hffff);
		bus(1'b0, 8'h20, 16'h0000);
		chk("unmapped", 16'h0000, rd);
		$display("register test done");
	endtask
	task automatic t_core();
		bus(1'b1, OFS_ACCUMULATOR, 16'ha5c3);
		// Upper lane only: low byte must survive
		avs_byteenable <= 4'h2;
		bus(1'b1, OFS_ACCUMULATOR, 16'h5a00);
		avs_byteenable <= 4'h3;
		cpurb_dec_model_inst.wr(SEL_ACC, 1'b1, 16'h1234);
		@(posedge core_clk);
		chk("byte write", 16'h5a34, file_out.acc);
		cpurb_dec_model_inst.wr(SEL_IDX, 1'b0, 16'hbeef);
		@(posedge core_clk);
		chk("index", 16'hbeef, file_out.idx);
		$display("core write test done");
	endtask
	task automatic t_alu();
		logic [22:0] rows [8] = '{{OP_ADD, 8'h0f, 8'h01, 5'h1f}, {OP_ADD, 8'h7f, 8'h01, 5'h1f},
			{OP_ADD, 8'hff, 8'h01, 5'h1f}, {OP_SUB, 8'h00, 8'h01, 5'h1f},
			{OP_ADD, 8'h12, 8'h34, 5'h02}, {OP_ADD, 8'h01, 8'h01, 5'h00},
			{OP_SHL, 8'h80, 8'h00, 5'h05}, {OP_SHR, 8'h01, 8'h00, 5'h0f}};
		logic [7:0] a, b, r;
		logic [4:0] flg, af;
		logic c, h, v;
		logic [1:0] op;
		flg = 5'h00;
		foreach (rows[k]) begin
			{op, a, b, af} = rows[k];
			bus(1'b1, OFS_ACCUMULATOR, {8'ha5, a});
			bus(1'b1, OFS_TEMPORARY_ACCUMULATOR, {8'h00, b});
			cpurb_dec_model_inst.alu(cpurb_op_e'(op), 1'b0, af);
			@(posedge core_clk);
			case (op)
				OP_ADD: {c, r} = a + b;
				OP_SUB: {c, r} = a - b;
				OP_SHL: {c, r} = {a, 1'b0};
				default: {r, c} = {1'b0, a};
			endcase
			h = op == OP_ADD ? a[3:0] + b[3:0] > 15 : a[3:0] < b[3:0];
			v = (op == OP_ADD ? a[7] == b[7] : op == OP_SUB && a[7] != b[7]) && r[7] != a[7];
			flg = (flg & ~af) | ({h, r[7], r == 8'h00, v, c} & af);
			chk("acc", {8'ha5, r}, file_out.acc);
			chk("flags", {8'h00, flg[4], 1'b0, 2'h3, flg[3:0]}, file_out.ps);
		end
		bus(1'b1, OFS_ACCUMULATOR, 16'h8000);
		bus(1'b1, OFS_TEMPORARY_ACCUMULATOR, 16'h8000);
		cpurb_dec_model_inst.alu(OP_ADD, 1'b1, 5'h0c);
		@(posedge core_clk);
		chk("wide sum", 16'h0000, file_out.acc);
		chk("wide flags", 16'h0004, file_out.ps & 16'h000c);
		$display("arithmetic test done");
	endtask
	task automatic t_addr();
		logic [15:0] da;
		for (int w = 0; w < 8; w++) begin
			bus(1'b1, OFS_STATUS_WORD, {5'(w * 4 + 3), 3'(w), 8'h30});
			da = w % 2 == 1 ? 16'h00ff - 16'(w) : 16'h007f - 16'(w);
			opcode_low <= 3'(w);
			direct_addr <= da;
			repeat (2) @(posedge core_clk);
			chk("general", {8'h01, 5'(w * 4 + 3), 3'(w)}, general_addr);
			chk("mapped", w % 2 == 1 ? da + 16'(w) * 16'h0080 : da, mapped_addr);
			bus(1'b0, OFS_MAP_STATUS, 16'h0000);
			chk("status general", {8'h01, 5'(w * 4 + 3), 3'(w)}, rd);
			chk("status mapped", w % 2 == 1 ? da + 16'(w) * 16'h0080 : da, rd_hi);
		end
		$display("address test done");
	endtask
	task automatic t_irq();
		logic [4:0] k;
		for (int j = 0; j < 32; j++) begin
			k = 5'(j);
			irq_pending <= j != 28;
			irq_level <= k[1:0];
			bus(1'b1, OFS_STATUS_WORD, {9'h000, k[4], k[3:2], 4'h0});
			repeat (2) @(posedge core_clk);
			chk("irq", 16'(j != 28 && k[4] && k[1:0] < k[3:2]), 16'(irq_accept));
		end
		$display("interrupt test done");
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_regs();
		t_core();
		t_alu();
		t_addr();
		t_irq();
		end_sim();
	end
endmodule
